// >>> hdl/ode_pkg.sv
// shared types and constants of the pwm output disable block
`default_nettype none

package ode_pkg;

    // =========================================================
    // sizes
    localparam int unsigned FAULT_PINS = 5;          // inputs 0..3 and 8
    localparam int unsigned FAULT_PIN8 = 4;          // index of input 8
    localparam int unsigned PWM_PAIRS  = 3;
    localparam int unsigned PRE_W      = 7;

    // =========================================================
    // low level sampling
    localparam logic [4:0] LOW_SAMPLES   = 5'h10;    // 16 consecutive samples
    localparam logic [6:0] DIV8_MASK     = 7'h07;
    localparam logic [6:0] DIV16_MASK    = 7'h0f;
    localparam logic [6:0] DIV128_MASK   = 7'h7f;
    localparam logic [6:0] PRE_RESET     = 7'h00;
    localparam logic [4:0] CNT_RESET     = 5'h00;

    // =========================================================
    // options
    localparam logic EVENT_LINK_BUILT = 1'b1;        // clear for the variant without it

    // =========================================================
    // types
    typedef enum logic [1:0]
    {
        ODE_DET_EDGE      = 2'h0,
        ODE_DET_LOW_DIV8  = 2'h1,
        ODE_DET_LOW_DIV16 = 2'h2,
        ODE_DET_LOW_DIV128= 2'h3
    } ode_det_mode_t;

    typedef struct packed
    {
        logic div128;
        logic div16;
        logic div8;
    } ode_tick_t;

    typedef struct packed
    {
        logic [PWM_PAIRS-1:0] hi;
        logic [PWM_PAIRS-1:0] lo;
        logic [PWM_PAIRS-1:0] active_high;
    } ode_pwm_t;

    typedef struct packed
    {
        logic [FAULT_PINS-1:0] fault;
        logic                  cmp;
        logic                  osc;
        logic                  sw;
        logic                  evt;
    } ode_flags_t;

endpackage : ode_pkg

`default_nettype wire

// >>> hdl/ode_fault_det.sv
// one fault input pin: synchroniser, edge and low level detection
`default_nettype none

module ode_fault_det
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    // pin and setup
    input  wire logic               pin_n,
    input  wire ode_pkg::ode_det_mode_t mode,
    input  wire ode_pkg::ode_tick_t tick,
    // results
    output logic                    detect,
    output logic                    pin_low
);
    import ode_pkg::*;

    typedef struct packed
    {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [4:0] cnt;
        logic       detect;
    } ode_det_state_t;

    ode_det_state_t state_ff;
    ode_det_state_t nxt_state;

    function automatic logic sel_tick(input ode_det_mode_t m, input ode_tick_t t);
        logic r;
        r = 1'b0;
        unique case (m)
            ODE_DET_EDGE:       r = 1'b0;
            ODE_DET_LOW_DIV8:   r = t.div8;
            ODE_DET_LOW_DIV16:  r = t.div16;
            ODE_DET_LOW_DIV128: r = t.div128;
        endcase
        return r;
    endfunction : sel_tick

    always_comb
    begin
        nxt_state        = state_ff;
        nxt_state.sync1  = pin_n;
        nxt_state.sync2  = state_ff.sync1;
        nxt_state.prev   = state_ff.sync2;
        nxt_state.detect = 1'b0;
        if (mode == ODE_DET_EDGE)
        begin
            nxt_state.cnt    = CNT_RESET;
            nxt_state.detect = state_ff.prev & ~state_ff.sync2;
        end
        else if (sel_tick(mode, tick))
        begin
            // saturate so a held low reports once per episode
            if (state_ff.sync2)
            begin
                nxt_state.cnt = CNT_RESET;
            end
            else if (state_ff.cnt != LOW_SAMPLES)
            begin
                nxt_state.cnt    = state_ff.cnt + 5'h01;
                nxt_state.detect = (state_ff.cnt == LOW_SAMPLES - 5'h01);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, cnt: 5'h00, detect: 1'b0};
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
        end
    end

    assign detect  = state_ff.detect;
    assign pin_low = ~state_ff.sync2;

endmodule : ode_fault_det

`default_nettype wire

// >>> hdl/ode_output_disable.sv
// pwm output disable: fault pins, output comparison and forced float
`default_nettype none

module ode_output_disable
(
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rstn,
    input  wire logic                                   ce,
    // fault pins, bit 4 is input 8
    input  wire logic [ode_pkg::FAULT_PINS-1:0]         fault_input_n,
    input  wire ode_pkg::ode_det_mode_t [ode_pkg::FAULT_PINS-1:0] det_mode,
    // pwm timer unit levels
    input  wire ode_pkg::ode_pwm_t                      pwm,
    // other triggers
    input  wire logic                                   osc_stop,
    input  wire logic                                   sw_force,
    input  wire logic                                   event_in,
    // flag clears and interrupt enables
    input  wire ode_pkg::ode_flags_t                    flag_clr,
    input  wire logic [ode_pkg::FAULT_PINS-1:0]         irq_en_fault,
    input  wire logic                                   irq_en_cmp,
    // results
    output var ode_pkg::ode_flags_t                     flags,
    output logic                                        cpwm_hiz,
    output logic                                        ch0_hiz,
    output logic                                        irq_req
);
    import ode_pkg::*;

    typedef struct packed
    {
        logic [PRE_W-1:0] pre;
        logic             osc_s1;
        logic             osc_s2;
        ode_flags_t       flags;
        logic             cpwm_hiz;
        logic             ch0_hiz;
        logic             irq;
    } ode_state_t;

    ode_state_t state_ff;
    ode_state_t nxt_state;

    ode_tick_t             tick;
    logic [FAULT_PINS-1:0] det;
    logic [FAULT_PINS-1:0] pin_low;
    logic [PWM_PAIRS-1:0]  both_active;

    // =========================================================
    // sample ticks, one prescaler shared by every pin
    assign tick.div8   = (state_ff.pre & DIV8_MASK)  == DIV8_MASK;
    assign tick.div16  = (state_ff.pre & DIV16_MASK) == DIV16_MASK;
    assign tick.div128 = state_ff.pre == DIV128_MASK;

    // =========================================================
    // fault pin detectors
    generate
        for (genvar i = 0; i < FAULT_PINS; i++)
        begin : g_det
            ode_fault_det u_det
            (
                .clk     (clk),
                .rstn    (rstn),
                .ce      (ce),
                .pin_n   (fault_input_n[i]),
                .mode    (det_mode[i]),
                .tick    (tick),
                .detect  (det[i]),
                .pin_low (pin_low[i])
            );
        end
    endgenerate

    // =========================================================
    // output level comparison, pins share our clock so no sync
    generate
        for (genvar p = 0; p < PWM_PAIRS; p++)
        begin : g_cmp
            assign both_active[p] = ~((pwm.hi[p] ^ pwm.active_high[p]) |
                                      (pwm.lo[p] ^ pwm.active_high[p]));
        end
    endgenerate

    // set beats clear; a clear is refused while the cause persists
    function automatic logic upd_flag(input logic cur, input logic set, input logic clr, input logic cause);
        return set | (cur & ~(clr & ~cause));
    endfunction : upd_flag

    // =========================================================
    // next state
    always_comb
    begin
        nxt_state        = state_ff;
        nxt_state.pre    = state_ff.pre + 7'h01;
        nxt_state.osc_s1 = osc_stop;
        nxt_state.osc_s2 = state_ff.osc_s1;

        for (int k = 0; k < FAULT_PINS; k++)
        begin
            nxt_state.flags.fault[k] = upd_flag(state_ff.flags.fault[k], det[k],
                                                flag_clr.fault[k], pin_low[k]);
        end
        nxt_state.flags.cmp = upd_flag(state_ff.flags.cmp, |both_active,
                                       flag_clr.cmp, |both_active);
        nxt_state.flags.osc = upd_flag(state_ff.flags.osc, state_ff.osc_s2,
                                       flag_clr.osc, state_ff.osc_s2);
        nxt_state.flags.sw  = upd_flag(state_ff.flags.sw, sw_force,
                                       flag_clr.sw, 1'b0);
        // event pulse is the whole cause; absent option never sets
        nxt_state.flags.evt = upd_flag(state_ff.flags.evt, event_in & EVENT_LINK_BUILT,
                                       flag_clr.evt, 1'b0);

        nxt_state.cpwm_hiz = (|nxt_state.flags.fault[FAULT_PIN8-1:0]) |
                             nxt_state.flags.cmp |
                             nxt_state.flags.osc | nxt_state.flags.sw |
                             nxt_state.flags.evt;
        nxt_state.ch0_hiz  = nxt_state.flags.fault[FAULT_PIN8] |
                             nxt_state.flags.osc | nxt_state.flags.sw |
                             nxt_state.flags.evt;
        nxt_state.irq      = (|(nxt_state.flags.fault & irq_en_fault)) |
                             (nxt_state.flags.cmp & irq_en_cmp);
    end

    // =========================================================
    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= '0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
        end
    end

    assign flags    = state_ff.flags;
    assign cpwm_hiz = state_ff.cpwm_hiz;
    assign ch0_hiz  = state_ff.ch0_hiz;
    assign irq_req  = state_ff.irq;

endmodule : ode_output_disable

`default_nettype wire

// >>> test/ode_chk.sv
// assertions on the output disable ports
`default_nettype none

module ode_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // causes
    input wire logic [ode_pkg::FAULT_PINS-1:0] fault_input_n,
    input wire ode_pkg::ode_det_mode_t [ode_pkg::FAULT_PINS-1:0] det_mode,
    input wire ode_pkg::ode_pwm_t pwm,
    input wire logic osc_stop,
    input wire logic sw_force,
    input wire logic event_in,
    input wire ode_pkg::ode_flags_t flag_clr,
    input wire logic irq_en_cmp,
    // results
    input wire ode_pkg::ode_flags_t flags,
    input wire logic cpwm_hiz,
    input wire logic ch0_hiz,
    input wire logic irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import ode_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ========
    // helpers
    logic [7:0] low_ff;
    logic [7:0] nxt_low;
    logic [PWM_PAIRS-1:0] both;
    assign both = (pwm.hi & pwm.lo & pwm.active_high) | ~(pwm.hi | pwm.lo | pwm.active_high);
    // saturates so a long low never wraps back into range
    assign nxt_low = fault_input_n[1] ? 8'h00 : low_ff + {7'h00, low_ff != 8'hff};
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            low_ff <= 8'h00;
        else
            low_ff <= nxt_low;
    sequence fall0_s;
        $fell(fault_input_n[0]) && det_mode[0] == ODE_DET_EDGE;
    endsequence
    sequence osc_s;
        osc_stop [*3];
    endsequence
    // ========
    // properties
    edge_float_a: assert property (fall0_s |-> ##4 flags.fault[0] && cpwm_hiz)
        else $error("input 0 edge missed");
    ch0_float_a: assert property ($fell(fault_input_n[4]) && det_mode[4] == ODE_DET_EDGE |-> ##4 ch0_hiz)
        else $error("input 8 edge missed");
    lvl_early_a: assert property (low_ff == 8'h64 && det_mode[1] != ODE_DET_EDGE |-> !flags.fault[1])
        else $error("level seen too early");
    lvl_div8_a: assert property (low_ff == 8'h8c && det_mode[1] == ODE_DET_LOW_DIV8 |-> flags.fault[1])
        else $error("level seen too late");
    cmp_float_a: assert property (|both |=> flags.cmp && cpwm_hiz)
        else $error("overlap not floated");
    osc_float_a: assert property (osc_s |=> flags.osc && cpwm_hiz && ch0_hiz)
        else $error("stop not floated");
    sw_float_a: assert property (sw_force |=> flags.sw && cpwm_hiz && ch0_hiz)
        else $error("force not floated");
    evt_float_a: assert property (event_in |=> flags.evt && cpwm_hiz && ch0_hiz)
        else $error("event not floated");
    irq_cmp_a: assert property (flags.cmp && irq_en_cmp && $past(irq_en_cmp) |-> irq_req)
        else $error("irq missing");
    irq_idle_a: assert property (flags.fault == '0 && !flags.cmp |-> !irq_req)
        else $error("irq without flag");
    hiz_hold_a: assert property (cpwm_hiz && flag_clr == '0 |=> cpwm_hiz)
        else $error("float dropped");
    sw_clr_a: assert property (flag_clr.sw && !sw_force |=> !flags.sw)
        else $error("clear ignored");
endmodule : ode_chk

`default_nettype wire

// >>> test/ode_partner.sv
// fault sources and pwm timer pins
`default_nettype none

module ode_partner
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bench requests
    input wire logic [ode_pkg::FAULT_PINS-1:0] pull_low,
    input wire logic [ode_pkg::PWM_PAIRS-1:0] overlap,
    // pins
    output logic [ode_pkg::FAULT_PINS-1:0] fault_input_n,
    output var ode_pkg::ode_pwm_t pwm
);
    timeunit 1ns;
    timeprecision 1ps;
    import ode_pkg::*;
    logic [2:0] cnt_ff;
    // pull-ups keep idle fault lines high
    assign fault_input_n = ~pull_low;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            cnt_ff <= 3'h0;
        else
            cnt_ff <= cnt_ff + 3'h1;
    // pair 1 is active low, so overlap drives both to 0
    always_comb
    begin
        pwm.active_high = 3'h5;
        for (int i = 0; i < PWM_PAIRS; i++)
        begin
            pwm.hi[i] = overlap[i] ? pwm.active_high[i] : cnt_ff[2];
            pwm.lo[i] = overlap[i] ? pwm.active_high[i] : ~cnt_ff[2];
        end
    end
endmodule : ode_partner

`default_nettype wire

// >>> test/pwm_output_emergency_disable_tb_top.sv
// bench for the pwm output disable block
`default_nettype none

module pwm_output_emergency_disable_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ode_pkg::*;
    logic clk, rstn, ce, osc_stop, sw_force, event_in, irq_en_cmp;
    logic cpwm_hiz, ch0_hiz, irq_req;
    logic [4:0] pull_low, fault_input_n, irq_en_fault;
    logic [2:0] overlap;
    ode_det_mode_t [4:0] det_mode;
    ode_pwm_t pwm;
    ode_flags_t flag_clr, flags;
    int fails, compares, cyc;

    ode_output_disable dut_u
    (
        .clk          (clk),
        .rstn         (rstn),
        .ce           (ce),
        .fault_input_n(fault_input_n),
        .det_mode     (det_mode),
        .pwm          (pwm),
        .osc_stop     (osc_stop),
        .sw_force     (sw_force),
        .event_in     (event_in),
        .flag_clr     (flag_clr),
        .irq_en_fault (irq_en_fault),
        .irq_en_cmp   (irq_en_cmp),
        .flags        (flags),
        .cpwm_hiz     (cpwm_hiz),
        .ch0_hiz      (ch0_hiz),
        .irq_req      (irq_req)
    );
    ode_partner part_u
    (
        .clk          (clk),
        .rstn         (rstn),
        .pull_low     (pull_low),
        .overlap      (overlap),
        .fault_input_n(fault_input_n),
        .pwm          (pwm)
    );

    // ========
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic clr;
        flag_clr <= '1;
        tick(1);
        flag_clr <= '0;
        @(negedge clk);
        chk({flags, cpwm_hiz, ch0_hiz, irq_req}, 12'h000);
        tick(1);
    endtask : clr
    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // ========
    // scenarios
    task automatic t_edge(input int k, input logic [1:0] e);
        pull_low[k] <= 1'b1;
        tick(3);
        @(negedge clk);
        chk(flags.fault[k], 1'b0);
        @(negedge clk);
        chk({flags.fault[k], cpwm_hiz, ch0_hiz, irq_req}, {1'b1, e, 1'b1});
        tick(1);
        pull_low[k] <= 1'b0;
        tick(4);
        clr();
    endtask : t_edge
    task automatic t_level;
        int n;
        int d;
        for (int m = 1; m < 4; m++)
        begin
            d = (m == 3) ? 128 : 8 * m;
            det_mode[1] <= ode_det_mode_t'(m);
            pull_low[1] <= 1'b1;
            n = 0;
            while (flags.fault[1] !== 1'b1 && n < 3000)
            begin
                @(negedge clk);
                n++;
            end
            chk(n >= 15 * d && n <= 16 * d + 6, 1'b1);
            tick(24);
            pull_low[1] <= 1'b0;
            // high spell must span a sample tick, else the saturated count never restarts
            tick(d + 4);
            clr();
        end
    endtask : t_level
    task automatic t_cmp;
        overlap[1] <= 1'b1;
        tick(2);
        flag_clr.cmp <= 1'b1;
        tick(1);
        flag_clr <= '0;
        @(negedge clk);
        chk({flags.cmp, cpwm_hiz, ch0_hiz, irq_req}, 4'hd);
        @(posedge clk);
        irq_en_cmp <= 1'b0;
        tick(1);
        @(negedge clk);
        chk({flags.cmp, irq_req}, 2'h2);
        @(posedge clk);
        overlap    <= '0;
        irq_en_cmp <= 1'b1;
        clr();
    endtask : t_cmp
    task automatic t_trig;
        for (int i = 0; i < 3; i++)
        begin
            osc_stop <= (i == 0);
            sw_force <= (i == 1);
            event_in <= (i == 2);
            tick(1);
            sw_force <= 1'b0;
            event_in <= 1'b0;
            tick(3);
            osc_stop <= 1'b0;
            @(negedge clk);
            chk({flags.osc, flags.sw, flags.evt, cpwm_hiz, ch0_hiz}, {i == 0, i == 1, i == 2, 2'h3});
            tick(3);
            clr();
        end
    endtask : t_trig

    // ========
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, well above the longest level run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    initial
    begin
        {rstn, osc_stop, sw_force, event_in, pull_low, overlap, flag_clr, fails, compares, cyc} = '0;
        ce = 1'b1;
        irq_en_fault = 5'h1f;
        irq_en_cmp = 1'b1;
        det_mode = '{default: ODE_DET_EDGE};
        tick(20);
        rstn <= 1'b1;
        tick(2);
        t_edge(0, 2'h2);
        t_edge(4, 2'h1);
        t_level();
        t_cmp();
        t_trig();
        stop_test();
    end
endmodule : pwm_output_emergency_disable_tb_top

bind ode_output_disable ode_chk chk_u
(
    .clk          (clk),
    .rstn         (rstn),
    .fault_input_n(fault_input_n),
    .det_mode     (det_mode),
    .pwm          (pwm),
    .osc_stop     (osc_stop),
    .sw_force     (sw_force),
    .event_in     (event_in),
    .flag_clr     (flag_clr),
    .irq_en_cmp   (irq_en_cmp),
    .flags        (flags),
    .cpwm_hiz     (cpwm_hiz),
    .ch0_hiz      (ch0_hiz),
    .irq_req      (irq_req)
);

`default_nettype wire
